// *** shared/nvmac_pkg.sv ***
// Operation
// - Small data part: upper addresses read zero
// - Unimplemented data write keeps pump off
// - Program access: 14-bit word, 13-bit address
// - Program addresses past the top wrap around
// - Data byte write erases then programs
// - Program words read singly, written four-wide
// - Internal timer sets write and erase length
// - Protection blocks only external programmer access
// - Program address bits beyond memory size are ignored
// - Space select bit 7, cleared by reset
// - Space select frozen while write runs
// - Start bits set-only, cleared by hardware
// - Write permit gates writes, zero after power-up
// - Warm reset mid-write sets abort, keeps address and data registers
// - Done flag set by hardware, software clears
// - Unlock port stores nothing, reads zero
// - Row erase bit turns program write into erase
// - Data byte ready the cycle after start
// - Data registers hold until read or write
// - Address pair reaches 256 bytes, 8K words
// - Write needs 55h, AAh, then start bit
// - Start needs permit; later clearing is harmless
// - Program read uses second cycle, fills both
// - Row erase uses address bits from bit 5 up to the program size (six bits at 2K words)
package nvmac_pkg;

  // Register map, 9-bit special function register addresses
  localparam int          SFR_AW       = 9;
  localparam logic [8:0]  ADDR_CTRL    = 9'h18C;
  localparam logic [8:0]  ADDR_UNLOCK  = 9'h18D;
  localparam logic [8:0]  ADDR_DATA_LO = 9'h10C;
  localparam logic [8:0]  ADDR_ADDR_LO = 9'h10D;
  localparam logic [8:0]  ADDR_DATA_HI = 9'h10E;
  localparam logic [8:0]  ADDR_ADDR_HI = 9'h10F;
  localparam logic [8:0]  ADDR_PFLAG2  = 9'h00D;

  // Control register bit positions
  localparam int CTRL_RD_BIT     = 0;
  localparam int CTRL_WR_BIT     = 1;
  localparam int CTRL_PERMIT_BIT = 2;
  localparam int CTRL_ABORT_BIT  = 3;
  localparam int CTRL_ERASE_BIT  = 4;
  localparam int CTRL_PSEL_BIT   = 7;
  localparam int PFLAG2_DONE_BIT = 4;

  // Unlock keys
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  // Word and address widths
  localparam int PROG_ADDR_W = 13;
  localparam int PROG_DATA_W = 14;
  localparam int ADDR_HI_W   = 5;
  localparam int DATA_HI_W   = 6;
  localparam int ROW_LSB     = 5;
  localparam int ROW_WORDS   = 32;
  localparam int BLOCK_WORDS = 4;

  // Sizes and fill values
  localparam int                     EE_BYTES_DEF   = 256;
  localparam int                     PROG_WORDS_DEF = 2048;
  localparam logic [PROG_DATA_W-1:0] ERASED_WORD    = 14'h3FFF;
  localparam logic [7:0]             UNIMPL_BYTE    = 8'h00;
  localparam logic [7:0]             RESET_BYTE     = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int WRITE_TIME_US    = 2000;
  localparam int WRITE_CYCLES_DEF = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

  // Register access request from the core
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [8:0]       addr;
    logic [7:0]       wdata;
  } nvmac_sfr_req_t;

  // Control register state
  typedef struct packed {
    logic psel;
    logic erase;
    logic abort;
    logic permit;
    logic wrStart;
    logic rdStart;
  } nvmac_ctrl_t;

  // Unlock sequence tracker
  typedef enum logic [1:0] {
    UL_IDLE  = 2'b00,
    UL_KEY1  = 2'b01,
    UL_ARMED = 2'b11
  } nvmac_unlock_t;

  // Operation sequencer
  typedef enum logic [1:0] {
    OP_IDLE   = 2'b00,
    OP_PREAD  = 2'b01,
    OP_TIMED  = 2'b11,
    OP_FINISH = 2'b10
  } nvmac_op_t;

endpackage

// *** verilog/nvmac_ctrl.sv ***
`timescale 1ns/10ps
module nvmac_ctrl #(
  parameter int EE_BYTES     = nvmac_pkg::EE_BYTES_DEF,
  parameter int PROG_WORDS   = nvmac_pkg::PROG_WORDS_DEF,
  parameter int WRITE_CYCLES = nvmac_pkg::WRITE_CYCLES_DEF
) (
  input  logic                      clk,
  input  logic                      rst_n,
  input  logic                      ce,
  input  nvmac_pkg::nvmac_sfr_req_t sfrReq,
  input  logic                      extResetPin_n,
  input  logic                      wdtReset,
  input  logic                      codeProtect,
  input  logic                      progAccessReq,
  output logic [7:0]                sfrRdData_q,
  output logic                      chargePumpOn_q,
  output logic                      cpuStall_q,
  output logic                      progAccessGrant_q
);
  import nvmac_pkg::*;

  localparam int EA    = $clog2(EE_BYTES);
  localparam int PA    = $clog2(PROG_WORDS);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  // Refuse sizes the address logic cannot serve
  generate
    if ((EE_BYTES != 128 && EE_BYTES != 256) || (PROG_WORDS < ROW_WORDS)
        || (PROG_WORDS > 8192) || ((1 << PA) != PROG_WORDS) || (WRITE_CYCLES < 1))
    begin : g_bad_params
      $error("nvmac_ctrl: unsupported size or timer parameter");
    end
  endgenerate

  nvmac_ctrl_t                ctrl_q;        // Control register
  nvmac_unlock_t              unlock_q;      // Unlock tracker
  nvmac_op_t                  op_q;          // Operation sequencer
  logic [CNT_W-1:0]           count_q;       // Write timer
  logic [7:0]                 addrLo_q;      // Address low byte
  logic [ADDR_HI_W-1:0]       addrHi_q;      // Address high bits
  logic [7:0]                 dataLo_q;      // Data low byte
  logic [DATA_HI_W-1:0]       dataHi_q;      // Data high bits
  logic                       done_q;        // Write done flag
  logic [PROG_ADDR_W-1:0]     opAddr_q;      // Latched target address
  logic [PROG_DATA_W-1:0]     opWord_q;      // Latched word or byte
  logic                       opProg_q;      // Target is program space
  logic                       opErase_q;     // Operation is a row erase
  logic                       opImpl_q;      // Target location exists
  logic                       extSync1_q;    // Reset pin sync stage 1
  logic                       extSync2_q;    // Reset pin sync stage 2
  logic                       reqSync1_q;    // Programmer request sync stage 1
  logic                       reqSync2_q;    // Programmer request sync stage 2

  logic [7:0]                 eeMem   [EE_BYTES];     // Data array
  logic [PROG_DATA_W-1:0]     progMem [PROG_WORDS];   // Program array
  logic [PROG_DATA_W-1:0]     progBuf [BLOCK_WORDS];  // Four-word latch

  logic                       warmReset;     // Pin or watchdog reset
  logic                       ctrlWr;        // Write to control register
  logic                       wrAccept;      // Write or erase launched
  logic                       rdAccept;      // Read launched
  logic                       eeImpl;        // Data address exists
  logic [PROG_ADDR_W-1:0]     progAddr;      // Joined address
  logic [7:0]                 eeRdByte;      // Addressed data byte
  logic [PROG_DATA_W-1:0]     progRdWord;    // Addressed program word
  logic                       rdClear;       // Hardware clears read start

  // Joined 13-bit address and implemented-location checks
  assign progAddr   = {addrHi_q, addrLo_q};
  assign eeImpl     = ({1'b0, addrLo_q} < 9'(EE_BYTES));
  assign eeRdByte   = eeImpl ? eeMem[addrLo_q[EA-1:0]] : UNIMPL_BYTE;
  assign progRdWord = progMem[progAddr[PA-1:0]];
  assign warmReset  = ~extSync2_q | wdtReset;
  assign ctrlWr     = sfrReq.wr && (sfrReq.addr == ADDR_CTRL);
  // Start only when armed, permitted and idle
  assign wrAccept   = ctrlWr && sfrReq.wdata[CTRL_WR_BIT] && (unlock_q == UL_ARMED)
                      && ctrl_q.permit && (op_q == OP_IDLE) && !ctrl_q.wrStart;
  assign rdAccept   = ctrlWr && sfrReq.wdata[CTRL_RD_BIT] && (op_q == OP_IDLE)
                      && !ctrl_q.wrStart && !wrAccept;
  assign rdClear    = ctrl_q.rdStart && ((op_q == OP_IDLE) || (op_q == OP_PREAD));

  // Two-stage synchroniser for the external reset pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extSync1_q <= 1'b1;
      extSync2_q <= 1'b1;
    end
    else if (ce)
    begin
      extSync1_q <= extResetPin_n;
      extSync2_q <= extSync1_q;
    end
  end

  // Control register: set-only starts, frozen select, abort capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= '0;
    else if (ce)
    begin
      if (warmReset)
      begin
        // Aborted write is flagged; other bits return to idle
        ctrl_q.abort   <= ctrl_q.abort | ctrl_q.wrStart;
        ctrl_q.psel    <= 1'b0;
        ctrl_q.erase   <= 1'b0;
        ctrl_q.permit  <= 1'b0;
        ctrl_q.wrStart <= 1'b0;
        ctrl_q.rdStart <= 1'b0;
      end
      else
      begin
        if (ctrlWr)
        begin
          // Select cannot move while a write runs
          if (!ctrl_q.wrStart)
            ctrl_q.psel <= sfrReq.wdata[CTRL_PSEL_BIT];
          ctrl_q.erase  <= sfrReq.wdata[CTRL_ERASE_BIT];
          ctrl_q.abort  <= sfrReq.wdata[CTRL_ABORT_BIT];
          ctrl_q.permit <= sfrReq.wdata[CTRL_PERMIT_BIT];
        end
        // Written zeros ignored; hardware clears at completion
        ctrl_q.rdStart <= (ctrl_q.rdStart & ~rdClear) | rdAccept;
        ctrl_q.wrStart <= (ctrl_q.wrStart & (op_q != OP_FINISH)) | wrAccept;
      end
    end
  end

  // Unlock tracker: only 55h then AAh then start arms a write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unlock_q <= UL_IDLE;
    else if (ce)
    begin
      if (warmReset)
        unlock_q <= UL_IDLE;
      else if (sfrReq.wr)
      begin
        case (unlock_q)
          UL_IDLE:
            unlock_q <= ((sfrReq.addr == ADDR_UNLOCK) && (sfrReq.wdata == UNLOCK_KEY1))
                        ? UL_KEY1 : UL_IDLE;
          UL_KEY1:
            unlock_q <= ((sfrReq.addr == ADDR_UNLOCK) && (sfrReq.wdata == UNLOCK_KEY2))
                        ? UL_ARMED : UL_IDLE;
          UL_ARMED:
            // Any further write, the start included, disarms
            unlock_q <= UL_IDLE;
          default:
            unlock_q <= UL_IDLE;
        endcase
      end
    end
  end

  // Operation sequencer, write timer, pump and stall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_q           <= OP_IDLE;
      count_q        <= '0;
      opAddr_q       <= '0;
      opWord_q       <= '0;
      opProg_q       <= 1'b0;
      opErase_q      <= 1'b0;
      opImpl_q       <= 1'b0;
      chargePumpOn_q <= 1'b0;
      cpuStall_q     <= 1'b0;
    end
    else if (ce)
    begin
      if (warmReset)
      begin
        op_q           <= OP_IDLE;
        count_q        <= '0;
        chargePumpOn_q <= 1'b0;
        cpuStall_q     <= 1'b0;
      end
      else
      begin
        case (op_q)
          OP_IDLE:
          begin
            if (wrAccept)
            begin
              opAddr_q  <= progAddr;
              opWord_q  <= {dataHi_q, dataLo_q};
              opProg_q  <= ctrl_q.psel;
              opErase_q <= ctrl_q.erase;
              opImpl_q  <= ctrl_q.psel | eeImpl;
              count_q   <= CNT_W'(WRITE_CYCLES - 1);
              // Non-final words of a block only fill the latch
              if (ctrl_q.psel && !ctrl_q.erase && (progAddr[1:0] != 2'(BLOCK_WORDS - 1)))
                op_q <= OP_FINISH;
              else
              begin
                op_q           <= OP_TIMED;
                chargePumpOn_q <= ctrl_q.psel | eeImpl;
                cpuStall_q     <= ctrl_q.psel;
              end
            end
            else if (rdAccept && ctrl_q.psel)
            begin
              op_q       <= OP_PREAD;
              cpuStall_q <= 1'b1;
            end
          end
          OP_PREAD:
          begin
            op_q       <= OP_IDLE;
            cpuStall_q <= 1'b0;
          end
          OP_TIMED:
          begin
            if (count_q == '0)
            begin
              op_q           <= OP_FINISH;
              chargePumpOn_q <= 1'b0;
              cpuStall_q     <= 1'b0;
            end
            else
              count_q <= count_q - CNT_W'(1);
          end
          OP_FINISH:
            op_q <= OP_IDLE;
          default:
            op_q <= OP_IDLE;
        endcase
      end
    end
  end

  // Array updates at completion of a timed or latch operation
  always_ff @(posedge clk)
  begin
    if (ce && !warmReset && (op_q == OP_FINISH))
    begin
      if (!opProg_q)
      begin
        // Byte write replaces the cell: implicit erase then program
        if (opImpl_q)
          eeMem[opAddr_q[EA-1:0]] <= opWord_q[7:0];
      end
      else if (opErase_q)
      begin
        // Whole 32-word row chosen by the upper address bits
        for (int i = 0; i < ROW_WORDS; i++)
          progMem[{opAddr_q[PA-1:ROW_LSB], 5'(i)}] <= ERASED_WORD;
      end
      else if (opAddr_q[1:0] != 2'(BLOCK_WORDS - 1))
        progBuf[opAddr_q[1:0]] <= opWord_q;
      else
      begin
        // Programming only clears bits, so the row must be erased first
        for (int i = 0; i < BLOCK_WORDS; i++)
        begin
          if (i == BLOCK_WORDS - 1)
            progMem[{opAddr_q[PA-1:2], 2'(i)}] <=
              progMem[{opAddr_q[PA-1:2], 2'(i)}] & opWord_q;
          else
            progMem[{opAddr_q[PA-1:2], 2'(i)}] <=
              progMem[{opAddr_q[PA-1:2], 2'(i)}] & progBuf[i];
          progBuf[i] <= ERASED_WORD;
        end
      end
    end
  end

  // Address registers: kept across warm reset, unimplemented bits absent
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addrLo_q <= RESET_BYTE;
      addrHi_q <= '0;
    end
    else if (ce && sfrReq.wr && !warmReset)
    begin
      if (sfrReq.addr == ADDR_ADDR_LO)
        addrLo_q <= sfrReq.wdata;
      if (sfrReq.addr == ADDR_ADDR_HI)
        addrHi_q <= sfrReq.wdata[ADDR_HI_W-1:0];
    end
  end

  // Data registers: hold read results until the next read or a write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataLo_q <= RESET_BYTE;
      dataHi_q <= '0;
    end
    else if (ce && !warmReset)
    begin
      if (rdAccept && !ctrl_q.psel)
        dataLo_q <= eeRdByte;
      else if (op_q == OP_PREAD)
        {dataHi_q, dataLo_q} <= progRdWord;
      else if (sfrReq.wr)
      begin
        if (sfrReq.addr == ADDR_DATA_LO)
          dataLo_q <= sfrReq.wdata;
        if (sfrReq.addr == ADDR_DATA_HI)
          dataHi_q <= sfrReq.wdata[DATA_HI_W-1:0];
      end
    end
  end

  // Done flag: hardware set wins over a software clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_q <= 1'b0;
    else if (ce)
    begin
      if (warmReset)
        done_q <= 1'b0;
      else if (op_q == OP_FINISH)
        done_q <= 1'b1;
      else if (sfrReq.wr && (sfrReq.addr == ADDR_PFLAG2))
        done_q <= sfrReq.wdata[PFLAG2_DONE_BIT];
    end
  end

  // Register read port, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sfrRdData_q <= RESET_BYTE;
    else if (ce && sfrReq.rd)
    begin
      case (sfrReq.addr)
        ADDR_CTRL:    sfrRdData_q <= {ctrl_q.psel, 2'b00, ctrl_q.erase, ctrl_q.abort,
                                      ctrl_q.permit, ctrl_q.wrStart, ctrl_q.rdStart};
        ADDR_UNLOCK:  sfrRdData_q <= RESET_BYTE;
        ADDR_DATA_LO: sfrRdData_q <= dataLo_q;
        ADDR_DATA_HI: sfrRdData_q <= {2'b00, dataHi_q};
        ADDR_ADDR_LO: sfrRdData_q <= addrLo_q;
        ADDR_ADDR_HI: sfrRdData_q <= {3'b000, addrHi_q};
        ADDR_PFLAG2:  sfrRdData_q <= {3'b000, done_q, 4'b0000};
        default:      sfrRdData_q <= RESET_BYTE;
      endcase
    end
  end

  // External programmer access: pin request synchronised, refused under code protection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reqSync1_q        <= 1'b0;
      reqSync2_q        <= 1'b0;
      progAccessGrant_q <= 1'b0;
    end
    else if (ce)
    begin
      reqSync1_q        <= progAccessReq;
      reqSync2_q        <= reqSync1_q;
      progAccessGrant_q <= reqSync2_q & ~codeProtect;
    end
  end

  // Checks on the sequencing
  rd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && ctrl_q.rdStart && (op_q == OP_IDLE) && !rdAccept && !warmReset) |=> !ctrl_q.rdStart)
    else $error("read start not cleared after data read");

  ee_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && rdAccept && !ctrl_q.psel && !warmReset) |=> (dataLo_q == $past(eeRdByte)))
    else $error("data byte not loaded on next cycle");

  unimpl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && rdAccept && !ctrl_q.psel && !eeImpl && !warmReset) |=> (dataLo_q == 8'h00))
    else $error("unimplemented data address did not read zero");

  prog_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && rdAccept && ctrl_q.psel && !warmReset) |=> (op_q == OP_PREAD) && cpuStall_q
    ##1 (!ce || warmReset || ({dataHi_q, dataLo_q} == $past(progRdWord))))
    else $error("program read not done in second cycle");

  permit_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && (op_q == OP_IDLE) && !ctrl_q.permit) |=> !ctrl_q.wrStart || $past(ctrl_q.wrStart))
    else $error("write started without permit");

  sel_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_q.wrStart && !warmReset) |=> $stable(ctrl_q.psel))
    else $error("space select changed during write");

  busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (op_q == OP_TIMED) |-> ctrl_q.wrStart)
    else $error("write start low during timed write");

  pump_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((op_q == OP_TIMED) && !opImpl_q) |-> !chargePumpOn_q)
    else $error("charge pump on for missing location");

  timer_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !warmReset && (op_q == OP_TIMED) && (count_q != '0))
    |=> (op_q == OP_TIMED) && (count_q == $past(count_q) - CNT_W'(1)))
    else $error("write timer did not count down");

  done_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !warmReset && (op_q == OP_FINISH)) |=> done_q && !ctrl_q.wrStart)
    else $error("write completion not flagged");

  abort_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && warmReset && ctrl_q.wrStart) |=> ctrl_q.abort && $stable(addrLo_q) && $stable(dataLo_q))
    else $error("aborted write not flagged or registers lost");

  unlock_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && sfrReq.rd && (sfrReq.addr == ADDR_UNLOCK)) |=> (sfrRdData_q == 8'h00))
    else $error("unlock port read not zero");

endmodule

// *** sim/nvmac_core_model.sv ***
`timescale 1ns/10ps
// Core-side model: register cycles issued the way running code would
module nvmac_core_model
  import nvmac_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [7:0]           sfrRdData_q,
  output nvmac_pkg::nvmac_sfr_req_t sfrReq
);
  // Quiet bus at time zero
  initial sfrReq = '0;

  // One write; released data is inverted so a stale value never looks valid
  task automatic wrReg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    sfrReq <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~d};
  endtask

  // One read; data is registered one cycle after the read edge
  task automatic rdReg(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    sfrReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    sfrReq.rd <= 1'b0;
    #1;
    d = sfrRdData_q;
  endtask

  // Key pair then the start write, nothing in between
  task automatic unlockStart(input logic [7:0] ctrl);
    wrReg(ADDR_UNLOCK, UNLOCK_KEY1);
    wrReg(ADDR_UNLOCK, UNLOCK_KEY2);
    wrReg(ADDR_CTRL, ctrl);
  endtask

  // Data byte fetch: address, select data space, start, then fetch
  task automatic readByte(input logic [7:0] a, output logic [7:0] d);
    wrReg(ADDR_ADDR_LO, a);
    wrReg(ADDR_CTRL, 8'h00);
    wrReg(ADDR_CTRL, 8'h01);
    rdReg(ADDR_DATA_LO, d);
  endtask

  // Software acknowledges the done flag
  task automatic clearDone();
    wrReg(ADDR_PFLAG2, 8'h00);
  endtask
endmodule

// *** sim/nvmac_ctrl_tb_top.sv ***
`timescale 1ns/10ps
// Self-checking bench for the nonvolatile access controller
module nvmac_ctrl_tb_top;
  import nvmac_pkg::*;
  localparam int WCYC = 8;           // Short write timer for simulation
  logic           clk = 1'b0;        // 100 MHz clock
  logic           rst_n = 1'b0;      // Power-on reset
  logic           wdtReset = 1'b0;   // Watchdog reset pulse
  logic           extPin_n = 1'b1;   // External reset pin
  logic           codeProtect = 1'b0;
  logic           progAccessReq = 1'b0;
  nvmac_sfr_req_t sfrReq;            // Driven by the core model
  logic [7:0]     rdData;            // Register read data
  logic           pumpOn;            // Charge pump enable
  logic           stall;             // Core stall
  logic           grant;             // Programmer access grant
  logic [7:0]     v;                 // Scratch read value
  int             failCount = 0;
  int             samplesChecked = 0;

  // Clock generator
  always #5 clk = ~clk;

  nvmac_core_model nvmac_core_model_inst (
    .clk(clk), .sfrRdData_q(rdData), .sfrReq(sfrReq));

  nvmac_ctrl #(.EE_BYTES(128), .WRITE_CYCLES(WCYC)) nvmac_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .sfrReq(sfrReq),
    .extResetPin_n(extPin_n), .wdtReset(wdtReset), .codeProtect(codeProtect),
    .progAccessReq(progAccessReq), .sfrRdData_q(rdData),
    .chargePumpOn_q(pumpOn), .cpuStall_q(stall), .progAccessGrant_q(grant));

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Shorthands onto the core model
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    nvmac_core_model_inst.wrReg(a, d);
  endtask

  task automatic expReg(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] d;
    nvmac_core_model_inst.rdReg(a, d);
    check(d, exp);
  endtask

  // Poll the busy bit under a bounded count
  task automatic waitIdle();
    logic [7:0] d;
    d = 8'h02;
    for (int i = 0; i < 40 && d[CTRL_WR_BIT] !== 1'b0; i++)
      nvmac_core_model_inst.rdReg(ADDR_CTRL, d);
    check(d & 8'h02, 8'h00);
  endtask

  // Set up address, data and permit, then unlock and start
  task automatic startWrite(input logic [7:0] a, input logic [7:0] d);
    wr(ADDR_ADDR_LO, a);
    wr(ADDR_DATA_LO, d);
    wr(ADDR_CTRL, 8'h04);
    nvmac_core_model_inst.unlockStart(8'h06);
    #1;
  endtask

  // Reset values of control and unlock port
  task automatic testReset();
    expReg(ADDR_CTRL, 8'h00);
    wr(ADDR_UNLOCK, 8'h5A);
    expReg(ADDR_UNLOCK, 8'h00);
    wr(ADDR_ADDR_HI, 8'hFF);
    expReg(ADDR_ADDR_HI, 8'h1F);
    $display("test reset done");
  endtask

  // Data byte write, busy behaviour, done flag, read back
  task automatic testDataWrite();
    startWrite(8'h05, 8'h3C);
    check({7'h00, pumpOn}, 8'h01);
    wr(ADDR_CTRL, 8'h80);
    expReg(ADDR_CTRL, 8'h02);
    waitIdle();
    expReg(ADDR_PFLAG2, 8'h10);
    nvmac_core_model_inst.clearDone();
    expReg(ADDR_PFLAG2, 8'h00);
    wr(ADDR_DATA_LO, 8'h00);
    nvmac_core_model_inst.readByte(8'h05, v);
    check(v, 8'h3C);
    expReg(ADDR_CTRL, 8'h00);
    expReg(ADDR_DATA_LO, 8'h3C);
    $display("test data write done");
  endtask

  // Unimplemented upper half of the data address range
  task automatic testUnimpl();
    startWrite(8'h85, 8'h77);
    check({7'h00, pumpOn}, 8'h00);
    waitIdle();
    nvmac_core_model_inst.clearDone();
    nvmac_core_model_inst.readByte(8'h85, v);
    check(v, 8'h00);
    nvmac_core_model_inst.readByte(8'h05, v);
    check(v, 8'h3C);
    $display("test unimplemented done");
  endtask

  // Broken key sequence and missing permit are refused
  task automatic testRefused();
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_UNLOCK, 8'h55);
    wr(ADDR_UNLOCK, 8'hAA);
    wr(ADDR_DATA_LO, 8'h11);
    wr(ADDR_CTRL, 8'h06);
    expReg(ADDR_CTRL, 8'h04);
    wr(ADDR_CTRL, 8'h00);
    nvmac_core_model_inst.unlockStart(8'h02);
    expReg(ADDR_CTRL, 8'h00);
    $display("test refused done");
  endtask

  // Watchdog reset, then reset pin, in mid-write
  task automatic testAbort();
    startWrite(8'h07, 8'h5A);
    @(posedge clk);
    wdtReset <= 1'b1;
    @(posedge clk);
    wdtReset <= 1'b0;
    expReg(ADDR_CTRL, 8'h08);
    expReg(ADDR_ADDR_LO, 8'h07);
    expReg(ADDR_DATA_LO, 8'h5A);
    wr(ADDR_CTRL, 8'h00);
    startWrite(8'h09, 8'hA5);
    @(posedge clk);
    extPin_n <= 1'b0;
    repeat (3) @(posedge clk);
    extPin_n <= 1'b1;
    expReg(ADDR_CTRL, 8'h08);
    expReg(ADDR_ADDR_LO, 8'h09);
    expReg(ADDR_DATA_LO, 8'hA5);
    wr(ADDR_CTRL, 8'h00);
    $display("test abort done");
  endtask

  // Row erase, four-word block write, aliased reads, then programmer gating
  task automatic testProgram();
    wr(ADDR_ADDR_HI, 8'h07);
    wr(ADDR_ADDR_LO, 8'h35);
    wr(ADDR_CTRL, 8'h94);
    nvmac_core_model_inst.unlockStart(8'h96);
    waitIdle();
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_ADDR_LO, 8'h20 + 8'(i));
      wr(ADDR_DATA_LO, 8'h50 + 8'(i));
      wr(ADDR_DATA_HI, 8'h2A);
      wr(ADDR_CTRL, 8'h84);
      nvmac_core_model_inst.unlockStart(8'h86);
      waitIdle();
    end
    wr(ADDR_ADDR_HI, 8'h1F);
    wr(ADDR_ADDR_LO, 8'h22);
    wr(ADDR_CTRL, 8'h81);
    #1;
    check({7'h00, stall}, 8'h01);
    @(posedge clk);
    #1;
    check({7'h00, stall}, 8'h00);
    expReg(ADDR_CTRL, 8'h80);
    expReg(ADDR_DATA_LO, 8'h52);
    expReg(ADDR_DATA_HI, 8'h2A);
    wr(ADDR_ADDR_LO, 8'h3F);
    wr(ADDR_CTRL, 8'h81);
    expReg(ADDR_DATA_HI, 8'h3F);
    expReg(ADDR_DATA_LO, 8'hFF);
    @(posedge clk);
    codeProtect <= 1'b1;
    progAccessReq <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({7'h00, grant}, 8'h00);
    @(posedge clk);
    codeProtect <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, grant}, 8'h01);
    $display("test program done");
  endtask

  // Verdict and end of run
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    testReset();
    testDataWrite();
    testUnimpl();
    testRefused();
    testAbort();
    testProgram();
    endOfTest();
  end

  // Watchdog against a hang
  initial
  begin
    #200000;
    failCount++;
    endOfTest();
  end
endmodule
